/* File: spf_pkg.sv */
// spf_pkg: register map, field positions, command codes and address constants
// assumes: one core clock, synchronous reset, an 8-bit register port
package spf_pkg;

   // ----------------------------------------------------------------
   // register offsets and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CSR_ADDR    = 8'h37;
   localparam logic [7:0] STATUS_ADDR = 8'h38;
   localparam logic [7:0] MASK_ADDR   = 8'h39;
   localparam logic [7:0] CSR_RESET   = 8'h00;
   localparam logic [1:0] EVT_RESET   = 2'h0;

   // ----------------------------------------------------------------
   // control/status field positions
   // ----------------------------------------------------------------
   localparam int BIT_IRQ_EN    = 7;
   localparam int BIT_BUSY      = 6;
   localparam int BIT_SIG_READ  = 5;
   localparam int EVT_DONE      = 0;
   localparam int EVT_TIMEOUT   = 1;

   // ----------------------------------------------------------------
   // lower five bit command patterns
   // ----------------------------------------------------------------
   localparam logic [4:0] CMD_READ_EN  = 5'h11;
   localparam logic [4:0] CMD_LOCK_SET = 5'h09;
   localparam logic [4:0] CMD_PG_WRITE = 5'h05;
   localparam logic [4:0] CMD_PG_ERASE = 5'h03;
   localparam logic [4:0] CMD_STORE    = 5'h01;

   // ----------------------------------------------------------------
   // timing and geometry
   // ----------------------------------------------------------------
   localparam logic [2:0] ARM_CYCLES = 3'h4;
   localparam int         WORD_BITS  = 6;
   localparam int         PAGE_WORDS = 64;

   // ----------------------------------------------------------------
   // boot start per size code, and first word of the protected section
   // ----------------------------------------------------------------
   localparam logic [13:0] BOOT13_3 = 14'h1F80;
   localparam logic [13:0] BOOT13_2 = 14'h1F00;
   localparam logic [13:0] BOOT13_1 = 14'h1E00;
   localparam logic [13:0] BOOT13_0 = 14'h1C00;
   localparam logic [13:0] BOOT14_3 = 14'h3F00;
   localparam logic [13:0] BOOT14_2 = 14'h3E00;
   localparam logic [13:0] BOOT14_1 = 14'h3C00;
   localparam logic [13:0] BOOT14_0 = 14'h3800;
   localparam logic [13:0] NRWW13   = 14'h1C00;
   localparam logic [13:0] NRWW14   = 14'h3800;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ARMED   = 2'b01,
      ST_PROGRAM = 2'b10
   } spf_state_t;

   function automatic logic [13:0] spf_boot_start(input logic [1:0] sz, input logic big);
      logic [13:0] r;
      r = BOOT13_0;
      case (sz)
         2'h3:    r = big ? BOOT14_3 : BOOT13_3;
         2'h2:    r = big ? BOOT14_2 : BOOT13_2;
         2'h1:    r = big ? BOOT14_1 : BOOT13_1;
         default: r = big ? BOOT14_0 : BOOT13_0;
      endcase
      return r;
   endfunction : spf_boot_start

endpackage : spf_pkg

/* File: spf_addr_if.sv */
// spf_addr_if: address split and boot decode results shared inside the block
// assumes: PCW is 13 or 14, checked by the top module
`timescale 1ns/10ps
interface spf_addr_if #(parameter int PCW = 13);
   logic [15:0]    zPtr;
   logic [PCW-7:0] pageSel;
   logic [5:0]     wordSel;
   logic           byteSel;
   logic           inRww;
   logic [PCW-1:0] bootStart;
   logic [PCW-1:0] appEnd;

   modport boot  (output bootStart, appEnd);
   modport split (input zPtr, output pageSel, wordSel, byteSel, inRww);
   modport top   (output zPtr, input pageSel, wordSel, byteSel, inRww, bootStart, appEnd);
endinterface : spf_addr_if

/* File: spf_boot_decode.sv */
// spf_boot_decode: synchronises the boot size pins and latches the decode once
// assumes: pins are static after reset; one core clock
`timescale 1ns/10ps
module spf_boot_decode
   import spf_pkg::*;
#(
   parameter int PCW = 13
) (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic bootSizeHi,
   input  wire logic bootSizeLo,
   spf_addr_if.boot  ab
);
   logic [1:0]     s1_q;
   logic [1:0]     s2_q;
   logic [1:0]     s3_q;
   logic           cap_q;
   logic [PCW-1:0] start_q;
   logic [13:0]    startFull;
   wire            settled = (s2_q == s3_q);

   assign startFull = spf_boot_start(s3_q, PCW == 14);

   always_ff @(posedge clock) begin
      s1_q <= {bootSizeHi, bootSizeLo};
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   // ----------------------------------------------------------------
   // capture once after release, held until the next reset
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         cap_q   <= 1'b0;
         start_q <= '0;
      end else if (!cap_q && settled) begin
         cap_q   <= 1'b1;
         start_q <= startFull[PCW-1:0];
      end
   end

   assign ab.bootStart = start_q;
   assign ab.appEnd    = start_q - 1'b1;

   a_boot_held: assert property (@(posedge clock) disable iff (rst)
      cap_q |=> $stable(start_q) && cap_q)
      else $error("boot start changed after capture");

   a_boot_table: assert property (@(posedge clock) disable iff (rst)
      !cap_q && settled |=> start_q[7:0] == 8'h00 || start_q[7:0] == 8'h80)
      else $error("boot start not aligned to a table entry");
endmodule : spf_boot_decode

/* File: spf_zsplit.sv */
// spf_zsplit: splits the Z pointer into page, word and byte selects
// assumes: PCW is 13 or 14; purely combinational
`timescale 1ns/10ps
module spf_zsplit
   import spf_pkg::*;
#(
   parameter int PCW = 13
) (
   spf_addr_if.split az
);
   localparam logic [PCW-1:0] NO_READ_WHILE_WRITE_SECTION_START = (PCW == 14) ? NRWW14[PCW-1:0] : NRWW13[PCW-1:0];

   // bits above PCW never reach any select
   assign az.pageSel = az.zPtr[PCW:7];
   assign az.wordSel = az.zPtr[6:1];
   assign az.byteSel = az.zPtr[0];
   assign az.inRww   = az.zPtr[PCW:1] < NO_READ_WHILE_WRITE_SECTION_START;
endmodule : spf_zsplit

/* File: spf_self_program_flash_control.sv */
// spf_self_program_flash_control: store-program-memory sequencer, control
// register, temporary page buffer and ready interrupt
// assumes: CPU core pulses spmStrobe/lpmStrobe with zPtr valid; flash
// macro pulses flashOpDone when erase or write is complete
`timescale 1ns/10ps

// What this block does
// - small variant boot start from size code
// - large variant boot start from size code
// - small variant protected section 0x1C00 up
// - large variant protected section 0x3800 up
// - small variant thirteen-bit counter, 64-word pages
// - large variant eight-bit page index
// - page number from upper Z bits
// - buffer word from Z six to one
// - top unused Z bits ignored
// - Z bit zero selects load byte
// - control register layout, resets to zero
// - ready interrupt while store enable clear
// - command armed four cycles, then cleared
// - busy bit set, blocks reads, cleared
// - only five command patterns act
module spf_self_program_flash_control
   import spf_pkg::*;
#(
   parameter int PC_WIDTH = 13
) (
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire logic [7:0]          regAddr,
   input  wire logic [7:0]          regWdata,
   input  wire logic                regWr,
   input  wire logic                regRd,
   output logic      [7:0]          regRdata,
   input  wire logic                bootSizeHi,
   input  wire logic                bootSizeLo,
   input  wire logic                globalIntEn,
   input  wire logic [15:0]         zPtr,
   input  wire logic                spmStrobe,
   input  wire logic [15:0]         storeData,
   input  wire logic                lpmStrobe,
   output logic                     lpmBlocked,
   output logic                     lpmByteSel,
   output logic [PC_WIDTH-1:0]      lpmWordAddr,
   output logic                     sigReadActive,
   input  wire logic                flashOpDone,
   output logic                     flashEraseStart,
   output logic                     flashWriteStart,
   output logic [PC_WIDTH-7:0]      flashPage,
   output logic                     lockSetStart,
   output logic [7:0]               lockData,
   input  wire logic [WORD_BITS-1:0] bufRdIdx,
   output logic [15:0]              bufRdData,
   output logic [PC_WIDTH-1:0]      bootResetAddr,
   output logic [PC_WIDTH-1:0]      appSectionEnd,
   output logic                     storeReadyIrq,
   output logic                     irqOut
);
   if (PC_WIDTH != 13 && PC_WIDTH != 14) begin : g_bad_width
      $error("PC_WIDTH must be 13 or 14");
   end

   spf_addr_if #(.PCW(PC_WIDTH)) ab ();

   spf_boot_decode #(.PCW(PC_WIDTH)) u_boot (
      .clock      (clock),
      .rst        (rst),
      .bootSizeHi (bootSizeHi),
      .bootSizeLo (bootSizeLo),
      .ab         (ab.boot)
   );

   spf_zsplit #(.PCW(PC_WIDTH)) u_zsplit (
      .az (ab.split)
   );

   assign ab.zPtr = zPtr;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   spf_state_t  state_q;
   logic [2:0]  armCnt_q;
   logic [4:0]  cmd_q;
   logic        signature_read_q;
   logic        irqEn_q;
   logic        busy_q;
   logic [1:0]  status_q;
   logic [1:0]  mask_q;
   logic [15:0] pageBuf_q [PAGE_WORDS];
   logic [7:0]  rdData_q;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire [4:0] cmdBits   = regWdata[4:0];
   wire       csrWr     = regWr && (regAddr == CSR_ADDR);
   wire       statusWr  = regWr && (regAddr == STATUS_ADDR);
   wire       maskWr    = regWr && (regAddr == MASK_ADDR);
   wire       cmdValid  = (cmdBits == CMD_READ_EN) || (cmdBits == CMD_LOCK_SET) ||
                          (cmdBits == CMD_PG_WRITE) || (cmdBits == CMD_PG_ERASE) ||
                          (cmdBits == CMD_STORE);
   // no new command while an erase or write runs
   wire       acceptCmd = csrWr && cmdValid && (state_q != ST_PROGRAM);
   wire       armed     = (state_q == ST_ARMED);
   wire       exec      = armed && spmStrobe && !acceptCmd;
   // a store with signature read armed neither writes the buffer nor clears busy
   wire       execStore = exec && (cmd_q == CMD_STORE) && !signature_read_q;
   wire       execProg  = exec && ((cmd_q == CMD_PG_WRITE) || (cmd_q == CMD_PG_ERASE));
   wire       execRdEn  = exec && (cmd_q == CMD_READ_EN);
   wire       execLock  = exec && (cmd_q == CMD_LOCK_SET);
   wire       timeout   = armed && !spmStrobe && !acceptCmd && (armCnt_q == 3'h0);
   wire       progDone  = (state_q == ST_PROGRAM) && flashOpDone;
   wire       storeEn   = (state_q != ST_IDLE);
   wire [1:0] evtSet    = {timeout, progDone || (exec && !execProg)};
   wire [4:0] cmdShown  = storeEn ? cmd_q : 5'h00;
   wire [7:0] csrRead   = {irqEn_q, busy_q, signature_read_q && storeEn, cmdShown};
   wire [7:0] rdMux     = (regAddr == CSR_ADDR)    ? csrRead :
                          (regAddr == STATUS_ADDR) ? {6'h00, status_q} :
                          (regAddr == MASK_ADDR)   ? {6'h00, mask_q} : 8'h00;

   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q  <= ST_IDLE;
         armCnt_q <= 3'h0;
         cmd_q    <= CSR_RESET[4:0];
         signature_read_q  <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE, ST_ARMED: begin
               if (acceptCmd) begin
                  state_q  <= ST_ARMED;
                  armCnt_q <= ARM_CYCLES - 3'h1;
                  cmd_q    <= cmdBits;
                  signature_read_q  <= regWdata[BIT_SIG_READ] && (cmdBits == CMD_STORE);
               end else if (execProg) begin
                  state_q <= ST_PROGRAM;
               end else if (exec || timeout) begin
                  state_q <= ST_IDLE;
                  signature_read_q <= 1'b0;
               end else if (armed) begin
                  armCnt_q <= armCnt_q - 3'h1;
               end
            end
            ST_PROGRAM: begin
               if (flashOpDone) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // control bits, busy, events
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         irqEn_q  <= CSR_RESET[BIT_IRQ_EN];
         busy_q   <= CSR_RESET[BIT_BUSY];
         status_q <= EVT_RESET;
         mask_q   <= EVT_RESET;
      end else begin
         if (csrWr) begin
            irqEn_q <= regWdata[BIT_IRQ_EN];
         end
         if (execProg && ab.inRww) begin
            busy_q <= 1'b1;
         end else if (execRdEn || execStore) begin
            busy_q <= 1'b0;
         end
         // set wins over a write-one clear in the same cycle
         status_q <= (status_q & ~(statusWr ? regWdata[1:0] : 2'h0)) | evtSet;
         if (maskWr) begin
            mask_q <= regWdata[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // temporary page buffer; re-enable aborts a partial load
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst || execRdEn) begin
         for (int i = 0; i < PAGE_WORDS; i++) begin
            pageBuf_q[i] <= 16'hFFFF;
         end
      end else if (execStore) begin
         pageBuf_q[ab.wordSel] <= storeData;
      end
   end

   // ----------------------------------------------------------------
   // flash and load side outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         flashEraseStart <= 1'b0;
         flashWriteStart <= 1'b0;
         flashPage       <= '0;
         lockSetStart    <= 1'b0;
         lockData        <= 8'h00;
         lpmByteSel      <= 1'b0;
         lpmWordAddr     <= '0;
         bufRdData       <= 16'h0000;
         rdData_q        <= 8'h00;
      end else begin
         flashEraseStart <= execProg && (cmd_q == CMD_PG_ERASE);
         flashWriteStart <= execProg && (cmd_q == CMD_PG_WRITE);
         lockSetStart    <= execLock;
         bufRdData       <= pageBuf_q[bufRdIdx];
         if (execProg) begin
            flashPage <= ab.pageSel;
         end
         if (execLock) begin
            lockData <= storeData[7:0];
         end
         if (lpmStrobe) begin
            lpmByteSel  <= ab.byteSel;
            lpmWordAddr <= zPtr[PC_WIDTH:1];
         end
         rdData_q <= regRd ? rdMux : 8'h00;
      end
   end

   assign regRdata      = rdData_q;
   assign lpmBlocked    = lpmStrobe && busy_q && ab.inRww;
   assign sigReadActive = armed && signature_read_q;
   assign bootResetAddr = ab.bootStart;
   assign appSectionEnd = ab.appEnd;
   assign storeReadyIrq = irqEn_q && globalIntEn && !storeEn;
   assign irqOut        = |(status_q & mask_q);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_arm_holds: assert property (@(posedge clock) disable iff (rst)
      (state_q == ST_IDLE && acceptCmd) ##1 (!spmStrobe && !csrWr)[*3] |=> armed)
      else $error("command window shorter than four cycles");

   a_arm_expires: assert property (@(posedge clock) disable iff (rst)
      (state_q == ST_IDLE && acceptCmd) ##1 (!spmStrobe && !csrWr)[*4] |=> state_q == ST_IDLE && status_q[EVT_TIMEOUT])
      else $error("command window did not expire after four cycles");

   a_prog_holds: assert property (@(posedge clock) disable iff (rst)
      state_q == ST_PROGRAM && !flashOpDone |=> regRd |=> regRdata[0])
      else $error("store enable dropped during erase or write");

   a_bad_command: assert property (@(posedge clock) disable iff (rst)
      state_q == ST_IDLE && csrWr && !cmdValid |=> state_q == ST_IDLE)
      else $error("invalid command pattern started an action");

   a_busy_set: assert property (@(posedge clock) disable iff (rst)
      execProg && ab.inRww |=> busy_q ##1 (!lpmStrobe || !ab.inRww || lpmBlocked))
      else $error("busy not set or read not blocked");

   a_busy_clear: assert property (@(posedge clock) disable iff (rst)
      execStore |=> !busy_q)
      else $error("page load did not clear busy");

   a_ready_irq: assert property (@(posedge clock) disable iff (rst)
      $rose(storeEn) |-> !storeReadyIrq && $past(storeReadyIrq) == $past(irqEn_q && globalIntEn))
      else $error("ready interrupt wrong around store enable");

   a_page_select: assert property (@(posedge clock) disable iff (rst)
      execProg |=> flashPage == $past(zPtr[PC_WIDTH:7]) && (flashEraseStart || flashWriteStart))
      else $error("page number not taken from pointer");

   a_word_select: assert property (@(posedge clock) disable iff (rst)
      execStore |=> pageBuf_q[$past(zPtr[6:1])] == $past(storeData))
      else $error("buffer word not selected by pointer");

   a_byte_select: assert property (@(posedge clock) disable iff (rst)
      lpmStrobe |=> lpmByteSel == $past(zPtr[0]))
      else $error("load byte select not from pointer bit zero");

   a_sticky_status: assert property (@(posedge clock) disable iff (rst)
      status_q[EVT_DONE] && !statusWr |=> status_q[EVT_DONE])
      else $error("status bit lost without a clear");

   // one command per arm: the window closes on execution
   a_exec_clears: assert property (@(posedge clock) disable iff (rst)
      exec && !execProg |=> !storeEn)
      else $error("store enable still set after execution");

   // an erase or write ends only on the flash done pulse
   a_done_status: assert property (@(posedge clock) disable iff (rst)
      progDone |=> state_q == ST_IDLE && status_q[EVT_DONE])
      else $error("erase or write did not finish cleanly");

   a_start_pulse: assert property (@(posedge clock) disable iff (rst)
      flashEraseStart || flashWriteStart |=> !flashEraseStart && !flashWriteStart)
      else $error("flash start pulse longer than one cycle");

   // the read port shows zero outside its answer cycle
   a_read_idle: assert property (@(posedge clock) disable iff (rst)
      !regRd |=> regRdata == 8'h00)
      else $error("read data outside the cycle after a read");
endmodule : spf_self_program_flash_control

/* File: spf_cpu_model.sv */
// spf_cpu_model: CPU core side, issues store and load instructions
// assumes: spf_pkg compiled first; tasks are entered after a clock edge
`timescale 1ns/10ps
module spf_cpu_model
   import spf_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        lpmBlocked,
   output logic      [15:0] zPtr,
   output logic             spmStrobe,
   output logic      [15:0] storeData,
   output logic             lpmStrobe
);
   // --------
   // idle state
   // --------
   initial begin
      zPtr      = 16'h0000;
      spmStrobe = 1'h0;
      storeData = 16'h0000;
      lpmStrobe = 1'h0;
   end

   // --------
   // instructions
   // --------
   // pointer and data are scrambled after the strobe, so a late sample shows
   task automatic spm(input logic [15:0] z, input logic [15:0] d, input logic pageOp);
      @(posedge clock);
      spmStrobe <= 1'h1;
      zPtr      <= pageOp ? {z[15:7], 7'h00} : {z[15:1], 1'h0};
      storeData <= d;
      @(posedge clock);
      spmStrobe <= 1'h0;
      zPtr      <= ~z;
      storeData <= ~d;
   endtask : spm

   task automatic lpm(input logic [15:0] z, output logic blk);
      @(posedge clock);
      lpmStrobe <= 1'h1;
      zPtr      <= z;
      #1;
      blk = lpmBlocked;
      @(posedge clock);
      lpmStrobe <= 1'h0;
      zPtr      <= ~z;
   endtask : lpm
endmodule : spf_cpu_model

/* File: spf_self_program_flash_control_test.sv */
// spf_self_program_flash_control_test: self-checking bench, 13-bit variant
// assumes: package, interface, design and spf_cpu_model compiled first
`timescale 1ns/10ps
module spf_self_program_flash_control_test
   import spf_pkg::*;
;
   logic                 clock, rst, regWr, regRd, bootSizeHi, bootSizeLo, globalIntEn, flashOpDone;
   logic [7:0]           regAddr, regWdata, regRdata, lockData;
   logic [15:0]          zPtr, storeData, bufRdData;
   logic                 spmStrobe, lpmStrobe, lpmBlocked, lpmByteSel, sigReadActive;
   logic                 flashEraseStart, flashWriteStart, lockSetStart, storeReadyIrq, irqOut;
   logic [WORD_BITS-1:0] bufRdIdx;
   logic [6:0]           flashPage;
   logic [12:0]          lpmWordAddr, bootResetAddr, appSectionEnd;
   logic                 blk;
   int                   errors, checked;

   spf_self_program_flash_control #(.PC_WIDTH(13)) spf_self_program_flash_control_i (
      .clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .bootSizeHi(bootSizeHi), .bootSizeLo(bootSizeLo),
      .globalIntEn(globalIntEn), .zPtr(zPtr), .spmStrobe(spmStrobe), .storeData(storeData),
      .lpmStrobe(lpmStrobe), .lpmBlocked(lpmBlocked), .lpmByteSel(lpmByteSel),
      .lpmWordAddr(lpmWordAddr), .sigReadActive(sigReadActive), .flashOpDone(flashOpDone),
      .flashEraseStart(flashEraseStart), .flashWriteStart(flashWriteStart),
      .flashPage(flashPage), .lockSetStart(lockSetStart), .lockData(lockData),
      .bufRdIdx(bufRdIdx), .bufRdData(bufRdData), .bootResetAddr(bootResetAddr),
      .appSectionEnd(appSectionEnd), .storeReadyIrq(storeReadyIrq), .irqOut(irqOut));

   spf_cpu_model spf_cpu_model_i (.clock(clock), .lpmBlocked(lpmBlocked), .zPtr(zPtr),
      .spmStrobe(spmStrobe), .storeData(storeData), .lpmStrobe(lpmStrobe));

   // --------
   // clock and common tasks
   // --------
   initial begin
      clock = 1'h0;
      forever #2.5 clock = ~clock;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      regWr    <= 1'h1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clock);
      regWr    <= 1'h0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      regRd   <= 1'h1;
      regAddr <= a;
      @(posedge clock);
      regRd   <= 1'h0;
      #1;
      check(regRdata, exp);
   endtask : rdchk

   task automatic bufchk(input logic [5:0] i, input logic [15:0] exp);
      @(posedge clock);
      bufRdIdx <= i;
      @(posedge clock);
      #1;
      check(bufRdData, exp);
   endtask : bufchk

   task automatic do_reset();
      rst <= 1'h1;
      repeat (3) @(posedge clock);
      rst <= 1'h0;
      repeat (8) @(posedge clock);
   endtask : do_reset

   task automatic op_done();
      @(posedge clock);
      flashOpDone <= 1'h1;
      @(posedge clock);
      flashOpDone <= 1'h0;
   endtask : op_done

   // --------
   // scenarios
   // --------
   task automatic test_regs();
      rdchk(CSR_ADDR, 8'h00);
      rdchk(STATUS_ADDR, 8'h00);
      rdchk(MASK_ADDR, 8'h00);
      wr(8'h40, 8'hFF);
      rdchk(8'h40, 8'h00);
      wr(CSR_ADDR, 8'h40);
      rdchk(CSR_ADDR, 8'h00);
      $display("register map test done");
   endtask : test_regs

   task automatic test_boot();
      logic [12:0] start [4];
      start = '{13'h1C00, 13'h1E00, 13'h1F00, 13'h1F80};
      for (int c = 0; c < 4; c++) begin
         bootSizeHi <= c[1];
         bootSizeLo <= c[0];
         do_reset();
         check(bootResetAddr, start[c]);
         check(appSectionEnd, start[c] - 13'h0001);
         bootSizeHi <= ~c[1];
         repeat (8) @(posedge clock);
         check(bootResetAddr, start[c]);
      end
      $display("boot decode test done");
   endtask : test_boot

   // store issued in the last armed cycle, top pointer bits set
   task automatic test_store();
      wr(CSR_ADDR, 8'h01);
      rdchk(CSR_ADDR, 8'h01);
      spf_cpu_model_i.spm(16'hC00A, 16'h1234, 1'h0);
      rdchk(CSR_ADDR, 8'h00);
      bufchk(6'h05, 16'h1234);
      rdchk(STATUS_ADDR, 8'h01);
      wr(STATUS_ADDR, 8'h01);
      wr(MASK_ADDR, 8'h02);
      wr(CSR_ADDR, 8'h01);
      repeat (5) @(posedge clock);
      spf_cpu_model_i.spm(16'h0004, 16'hAAAA, 1'h0);
      rdchk(CSR_ADDR, 8'h00);
      bufchk(6'h02, 16'hFFFF);
      rdchk(STATUS_ADDR, 8'h02);
      check(irqOut, 1'h1);
      wr(MASK_ADDR, 8'h00);
      #1;
      check(irqOut, 1'h0);
      wr(MASK_ADDR, 8'h02);
      #1;
      check(irqOut, 1'h1);
      wr(STATUS_ADDR, 8'h02);
      #1;
      check(irqOut, 1'h0);
      $display("store and timeout test done");
   endtask : test_store

   task automatic test_refused();
      logic [7:0] bad [4];
      bad = '{8'h07, 8'h1F, 8'h13, 8'h0D};
      for (int i = 0; i < 4; i++) begin
         wr(CSR_ADDR, 8'h80 | bad[i]);
         rdchk(CSR_ADDR, 8'h80);
         spf_cpu_model_i.spm(16'h000E, 16'hBEEF, 1'h0);
         #1;
         check(flashEraseStart | flashWriteStart | lockSetStart, 1'h0);
      end
      wr(CSR_ADDR, 8'h21);
      #1;
      check(sigReadActive, 1'h1);
      spf_cpu_model_i.spm(16'h000E, 16'hBEEF, 1'h0);
      bufchk(6'h07, 16'hFFFF);
      wr(CSR_ADDR, 8'h09);
      spf_cpu_model_i.spm(16'h0000, 16'h55AB, 1'h0);
      #1;
      check(lockSetStart, 1'h1);
      check(lockData, 8'hAB);
      $display("command pattern test done");
   endtask : test_refused

   // busy cleared once by a page load, once by read enable
   task automatic test_erase();
      logic [7:0] clr [2];
      clr = '{8'h01, 8'h11};
      for (int k = 0; k < 2; k++) begin
         wr(CSR_ADDR, 8'h03);
         spf_cpu_model_i.spm(16'h0180, 16'h0000, 1'h1);
         #1;
         check(flashEraseStart, 1'h1);
         check(flashPage, 7'h03);
         rdchk(CSR_ADDR, 8'h43);
         wr(CSR_ADDR, 8'h11);
         spf_cpu_model_i.lpm(16'h0182, blk);
         check(blk, 1'h1);
         spf_cpu_model_i.lpm(16'h3803, blk);
         #1;
         check(blk, 1'h0);
         check(lpmByteSel, 1'h1);
         check(lpmWordAddr, 13'h1C01);
         op_done();
         rdchk(CSR_ADDR, 8'h40);
         wr(CSR_ADDR, clr[k]);
         spf_cpu_model_i.spm(16'h0040, 16'h5A5A, 1'h0);
         rdchk(CSR_ADDR, 8'h00);
      end
      wr(CSR_ADDR, 8'h05);
      spf_cpu_model_i.spm(16'hF7FE, 16'h0000, 1'h1);
      #1;
      check(flashWriteStart, 1'h1);
      check(flashPage, 7'h6F);
      rdchk(CSR_ADDR, 8'h45);
      op_done();
      wr(CSR_ADDR, 8'h11);
      spf_cpu_model_i.spm(16'h0000, 16'h0000, 1'h0);
      wr(CSR_ADDR, 8'h03);
      spf_cpu_model_i.spm(16'h3800, 16'h0000, 1'h1);
      #1;
      check(flashPage, 7'h70);
      rdchk(CSR_ADDR, 8'h03);
      op_done();
      rdchk(CSR_ADDR, 8'h00);
      $display("erase and write test done");
   endtask : test_erase

   task automatic test_irq();
      @(posedge clock);
      globalIntEn <= 1'h1;
      wr(CSR_ADDR, 8'h80);
      #1;
      check(storeReadyIrq, 1'h1);
      wr(CSR_ADDR, 8'h81);
      #1;
      check(storeReadyIrq, 1'h0);
      repeat (5) @(posedge clock);
      #1;
      check(storeReadyIrq, 1'h1);
      @(posedge clock);
      globalIntEn <= 1'h0;
      @(posedge clock);
      #1;
      check(storeReadyIrq, 1'h0);
      $display("ready interrupt test done");
   endtask : test_irq

   // --------
   // verdict, main sequence and watchdog
   // --------
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict

   initial begin
      rst         = 1'h1;
      regAddr     = 8'h00;
      regWdata    = 8'h00;
      regWr       = 1'h0;
      regRd       = 1'h0;
      bootSizeHi  = 1'h0;
      bootSizeLo  = 1'h0;
      globalIntEn = 1'h0;
      flashOpDone = 1'h0;
      bufRdIdx    = 6'h00;
      do_reset();
      test_regs();
      test_boot();
      test_store();
      test_refused();
      test_erase();
      test_irq();
      print_verdict();
   end

   // whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clock);
      errors++;
      $display("ERROR t=%0t watchdog expired", $time);
      print_verdict();
   end
endmodule : spf_self_program_flash_control_test
